// ### hw/sdm_pkg.sv
package sdm_pkg;
    // -----------------------------------------------------------------
    // register offsets (byte addresses)
    // -----------------------------------------------------------------
    localparam logic [7:0] SDM_OFS_CFG = 8'h00;
    localparam logic [7:0] SDM_OFS_CMD = 8'h04;
    localparam logic [7:0] SDM_OFS_RES0 = 8'h08;
    localparam logic [7:0] SDM_OFS_RES1 = 8'h0c;
    localparam logic [7:0] SDM_OFS_RES2 = 8'h10;
    localparam logic [7:0] SDM_OFS_CTRLW = 8'h14;
    localparam logic [7:0] SDM_OFS_TVEL = 8'h18;
    localparam logic [7:0] SDM_OFS_STAT = 8'h1c;
    localparam logic [7:0] SDM_OFS_ERRH = 8'h20;
    localparam logic [7:0] SDM_OFS_SCALE = 8'h24;
    localparam logic [7:0] SDM_OFS_AOFS = 8'h28;
    localparam logic [7:0] SDM_OFS_ACFG = 8'h2c;
    // -----------------------------------------------------------------
    // field positions
    // -----------------------------------------------------------------
    localparam int SDM_CFG_ACT_LSB = 0;
    localparam int SDM_CFG_MODE_LSB = 8;
    localparam int SDM_CMD_SAVE_BIT = 0;
    localparam int SDM_CMD_RESTART_BIT = 1;
    localparam int SDM_STAT_ERR_BIT = 0;
    localparam int SDM_STAT_OPEN_BIT = 1;
    localparam int SDM_STAT_SPEC_BIT = 2;
    localparam int SDM_STAT_CL_BIT = 3;
    localparam int SDM_STAT_BUSY_BIT = 4;
    localparam int SDM_STAT_FBP_LSB = 8;
    // -----------------------------------------------------------------
    // values
    // -----------------------------------------------------------------
    localparam logic [7:0] SDM_ACT_ON = 8'h02;
    localparam logic [7:0] SDM_ACT_RST = 8'h00;
    localparam logic [3:0] SDM_MODE_RST = 4'h0;
    localparam logic [31:0] SDM_RES_RST = 32'h0000_0000;
    localparam logic [15:0] SDM_CW_SHUTDOWN = 16'h0006;
    localparam logic [15:0] SDM_CW_ENABLE = 16'h000f;
    localparam logic [15:0] SDM_ERR_BASE = 16'h7300; // arbitrary code base
    localparam logic [10:0] SDM_RPM_HI = 11'd1000;
    localparam logic [10:0] SDM_RPM_LO = 11'd100;
    localparam logic [10:0] SDM_RPM_TEST = 11'd30;
    localparam int SDM_NFB = 3;
    // analog scaling: full code equals the maximum analog voltage
    localparam int SDM_ADC_W = 12;
    localparam int SDM_UMAX_MV = 10000;
    localparam int SDM_DEAD_MV = 20;
    localparam logic [12:0] SDM_ADC_FULL = 13'd4095;
    localparam logic [12:0] SDM_ADC_MID = 13'd2048;
    localparam logic [12:0] SDM_ADC_HALF = 13'd2047;
    // last code at or below the dead-zone voltage
    localparam logic [12:0] SDM_DEAD_CNT =
        13'((SDM_DEAD_MV * 4095) / SDM_UMAX_MV);
    localparam logic [1:0] SDM_RESP_OKAY = 2'b00;
    localparam logic [1:0] SDM_RESP_SLVERR = 2'b10;
endpackage

// ### hw/sdm_fb_check.sv
`timescale 1ns/1ns
module sdm_fb_check
    import sdm_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // control
    input wire logic start,
    input wire logic [SDM_NFB-1:0] fb_present,
    input wire logic [SDM_NFB-1:0] fb_sig_ok,
    input wire logic need_fb,
    // result
    output logic busy,
    output logic err_pulse,
    output logic [15:0] err_code
);
    typedef enum logic [2:0] {
        SDM_CK_IDLE = 3'b001,
        SDM_CK_SCAN = 3'b010,
        SDM_CK_DONE = 3'b100
    } sdm_ck_e;

    sdm_ck_e st_r, st_nxt;
    logic [1:0] idx_r;
    logic idx_last;
    logic sig_bad;
    logic cfg_bad;

    assign idx_last = (idx_r == 2'(SDM_NFB - 1));
    // nonzero resolution: sensor is checked, zero: skipped
    assign sig_bad = (st_r == SDM_CK_SCAN) && fb_present[idx_r] && !fb_sig_ok[idx_r];
    assign cfg_bad = (st_r == SDM_CK_DONE) && need_fb && (fb_present == '0);

    always_comb begin
        st_nxt = st_r;
        unique case (st_r)
            SDM_CK_IDLE: if (start) st_nxt = SDM_CK_SCAN;
            SDM_CK_SCAN: if (idx_last) st_nxt = SDM_CK_DONE;
            SDM_CK_DONE: st_nxt = SDM_CK_IDLE;
            default: st_nxt = SDM_CK_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= SDM_CK_IDLE;
            idx_r <= 2'd0;
            err_pulse <= 1'b0;
            err_code <= 16'h0000;
            busy <= 1'b0;
        end else begin
            st_r <= st_nxt;
            idx_r <= (st_r == SDM_CK_SCAN && !idx_last) ? idx_r + 2'd1 : 2'd0;
            err_pulse <= sig_bad || cfg_bad;
            if (sig_bad) begin
                err_code <= SDM_ERR_BASE | {14'd0, idx_r};
            end else if (cfg_bad) begin
                err_code <= SDM_ERR_BASE | 16'h000f;
            end
            busy <= (st_nxt != SDM_CK_IDLE);
        end
    end
endmodule

// ### hw/sdm_ctrl.sv
// The placing of the registers and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/1ns
module sdm_ctrl
    import sdm_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // axi4-lite write address
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // axi4-lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // pins
    input wire logic din1_pin,
    input wire logic clk_pin,
    input wire logic dir_pin,
    input wire logic [SDM_NFB-1:0] fb_sig_pin,
    // analog converter, same clock
    input wire logic [SDM_ADC_W-1:0] adc_code,
    // motion outputs
    output logic op_enabled,
    output logic closed_loop,
    output logic clkdir_mode,
    output logic step_pulse,
    output logic step_dir,
    output logic [31:0] target_vel,
    output logic fault
);
    // -----------------------------------------------------------------
    // helpers
    // -----------------------------------------------------------------
    function automatic logic [31:0] sdm_merge(input logic [31:0] old,
                                              input logic [31:0] wd,
                                              input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) r[i*8 +: 8] = wd[i*8 +: 8];
        end
        return r;
    endfunction

    function automatic logic [10:0] sdm_scale(input logic [12:0] span,
                                              input logic [10:0] maxr,
                                              input logic [12:0] full);
        logic [23:0] prod;
        prod = 24'(span) * 24'(maxr);
        return 11'(prod / 24'(full));
    endfunction

    function automatic logic [31:0] sdm_signed(input logic [10:0] mag,
                                               input logic neg);
        return neg ? 32'(-$signed({21'd0, mag})) : {21'd0, mag};
    endfunction

    // -----------------------------------------------------------------
    // pin synchronisers
    // -----------------------------------------------------------------
    logic [SDM_NFB+2:0] sync1_r, sync2_r;
    logic en_s, clk_s, dir_s, clk_d_r;
    logic [SDM_NFB-1:0] fb_ok_s;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            sync1_r <= '0;
            sync2_r <= '0;
            clk_d_r <= 1'b0;
        end else begin
            sync1_r <= {fb_sig_pin, dir_pin, clk_pin, din1_pin};
            sync2_r <= sync1_r;
            clk_d_r <= clk_s;
        end
    end

    assign en_s = sync2_r[0];
    assign clk_s = sync2_r[1];
    assign dir_s = sync2_r[2];
    assign fb_ok_s = sync2_r[SDM_NFB+2:3];

    // -----------------------------------------------------------------
    // axi4-lite handshake
    // -----------------------------------------------------------------
    logic aw_held_r, w_held_r;
    logic [7:0] awaddr_r;
    logic [31:0] wdata_r;
    logic [3:0] wstrb_r;
    logic wr_go, rd_go;
    logic aw_take, w_take;

    assign aw_take = s_axi_awvalid && s_axi_awready;
    assign w_take = s_axi_wvalid && s_axi_wready;
    assign wr_go = aw_held_r && w_held_r && !s_axi_bvalid;
    assign rd_go = s_axi_arvalid && s_axi_arready;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            awaddr_r <= 8'h00;
            wdata_r <= 32'h0000_0000;
            wstrb_r <= 4'h0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
        end else begin
            if (aw_take) awaddr_r <= s_axi_awaddr;
            if (w_take) begin
                wdata_r <= s_axi_wdata;
                wstrb_r <= s_axi_wstrb;
            end
            aw_held_r <= wr_go ? 1'b0 : (aw_held_r || aw_take);
            w_held_r <= wr_go ? 1'b0 : (w_held_r || w_take);
            s_axi_awready <= !(aw_held_r || aw_take) ||
                (s_axi_bvalid && s_axi_bready && !aw_take);
            s_axi_wready <= !(w_held_r || w_take) ||
                (s_axi_bvalid && s_axi_bready && !w_take);
        end
    end

    // -----------------------------------------------------------------
    // register decode
    // -----------------------------------------------------------------
    logic [31:0] cfg_r, saved_r, ctrlw_r, tvel_host_r;
    logic [31:0] res_r [SDM_NFB];
    logic [15:0] errh_r;
    logic err_r;
    logic [7:0] act_r;
    logic [3:0] mode_r;
    logic wr_cfg, wr_cmd, wr_ctrlw, wr_tvel, wr_stat, wr_hit;
    logic [31:0] wr_val_cmd;
    logic save_cmd, restart_cmd;

    assign wr_cfg = wr_go && (awaddr_r == SDM_OFS_CFG);
    assign wr_cmd = wr_go && (awaddr_r == SDM_OFS_CMD);
    assign wr_ctrlw = wr_go && (awaddr_r == SDM_OFS_CTRLW);
    assign wr_tvel = wr_go && (awaddr_r == SDM_OFS_TVEL);
    assign wr_stat = wr_go && (awaddr_r == SDM_OFS_STAT);
    assign wr_val_cmd = sdm_merge(32'h0000_0000, wdata_r, wstrb_r);
    assign save_cmd = wr_cmd && wr_val_cmd[SDM_CMD_SAVE_BIT];
    assign restart_cmd = wr_cmd && wr_val_cmd[SDM_CMD_RESTART_BIT];
    assign wr_hit = wr_cfg || wr_cmd || wr_ctrlw || wr_tvel || wr_stat ||
        (awaddr_r == SDM_OFS_RES0) || (awaddr_r == SDM_OFS_RES1) ||
        (awaddr_r == SDM_OFS_RES2);

    // -----------------------------------------------------------------
    // configuration: edit, save, restart
    // -----------------------------------------------------------------
    logic chk_start_r;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_r <= {20'd0, SDM_MODE_RST, SDM_ACT_RST};
            saved_r <= {20'd0, SDM_MODE_RST, SDM_ACT_RST};
            act_r <= SDM_ACT_RST;
            mode_r <= SDM_MODE_RST;
            ctrlw_r <= 32'h0000_0000;
            tvel_host_r <= 32'h0000_0000;
            chk_start_r <= 1'b1;
        end else begin
            if (wr_cfg) cfg_r <= sdm_merge(cfg_r, wdata_r, wstrb_r) & 32'h0000_0fff;
            if (save_cmd) saved_r <= cfg_r;
            if (restart_cmd) begin
                act_r <= saved_r[SDM_CFG_ACT_LSB +: 8];
                mode_r <= saved_r[SDM_CFG_MODE_LSB +: 4];
            end
            chk_start_r <= restart_cmd;
            if (wr_ctrlw) ctrlw_r <= sdm_merge(ctrlw_r, wdata_r, wstrb_r);
            if (wr_tvel) tvel_host_r <= sdm_merge(tvel_host_r, wdata_r, wstrb_r);
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < SDM_NFB; i++) res_r[i] <= SDM_RES_RST;
        end else begin
            for (int i = 0; i < SDM_NFB; i++) begin
                if (wr_go && awaddr_r == 8'(SDM_OFS_RES0 + 8'(4 * i)))
                    res_r[i] <= sdm_merge(res_r[i], wdata_r, wstrb_r);
            end
        end
    end

    // -----------------------------------------------------------------
    // mode decode
    // -----------------------------------------------------------------
    logic special, m_cl, m_clkdir, m_test, m_analog, m_joy, m_lo, m_ccw;
    logic [10:0] max_rpm;
    logic [12:0] aofs;

    assign special = (act_r == SDM_ACT_ON);
    assign m_cl = mode_r[3];
    assign m_clkdir = special && !mode_r[2] && !mode_r[1];
    assign m_test = special && !mode_r[2] && mode_r[1];
    assign m_ccw = mode_r[0];
    assign m_analog = special && mode_r[2];
    assign m_joy = mode_r[1];
    assign m_lo = mode_r[0];
    assign max_rpm = m_lo ? SDM_RPM_LO : SDM_RPM_HI;
    assign aofs = (m_analog && m_joy) ? SDM_ADC_MID : 13'd0;

    // -----------------------------------------------------------------
    // analog speed
    // -----------------------------------------------------------------
    logic [12:0] code, jdiff, jmag, nspan, jspan;
    logic jneg, n_dead, j_dead;
    logic [10:0] n_spd, j_spd;
    logic [31:0] ana_vel, spec_vel;

    assign code = {1'b0, adc_code};
    assign n_dead = (code <= SDM_DEAD_CNT);
    assign nspan = code;
    assign n_spd = n_dead ? 11'd0 : sdm_scale(nspan, max_rpm, SDM_ADC_FULL);
    assign jneg = (code < SDM_ADC_MID);
    assign jdiff = jneg ? (SDM_ADC_MID - code) : (code - SDM_ADC_MID);
    assign jmag = (jdiff > SDM_ADC_HALF) ? SDM_ADC_HALF : jdiff;
    assign j_dead = (jdiff <= SDM_DEAD_CNT);
    assign jspan = jmag;
    assign j_spd = j_dead ? 11'd0 : sdm_scale(jspan, max_rpm, SDM_ADC_HALF);
    // low direction input: clockwise, taken as positive
    assign ana_vel = m_joy ? sdm_signed(j_spd, jneg) : sdm_signed(n_spd, dir_s);
    assign spec_vel = m_test ? sdm_signed(SDM_RPM_TEST, m_ccw) : ana_vel;

    // -----------------------------------------------------------------
    // power state
    // -----------------------------------------------------------------
    logic op_en_nxt;
    logic [15:0] cw_lo;

    assign cw_lo = ctrlw_r[15:0];
    assign op_en_nxt = special ? en_s :
        (cw_lo == SDM_CW_ENABLE) ? 1'b1 :
        (cw_lo == SDM_CW_SHUTDOWN) ? 1'b0 : op_enabled;

    // -----------------------------------------------------------------
    // feedback check
    // -----------------------------------------------------------------
    logic [SDM_NFB-1:0] fb_present;
    logic chk_busy, chk_err;
    logic [15:0] chk_code;

    always_comb begin
        for (int i = 0; i < SDM_NFB; i++) fb_present[i] = (res_r[i] != 32'h0000_0000);
    end

    sdm_fb_check u_check (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .start(chk_start_r),
        .fb_present(fb_present),
        .fb_sig_ok(fb_ok_s),
        .need_fb(special && m_cl),
        .busy(chk_busy),
        .err_pulse(chk_err),
        .err_code(chk_code)
    );

    // -----------------------------------------------------------------
    // motion outputs and error
    // -----------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            op_enabled <= 1'b0;
            closed_loop <= 1'b0;
            clkdir_mode <= 1'b0;
            step_pulse <= 1'b0;
            step_dir <= 1'b0;
            target_vel <= 32'h0000_0000;
            fault <= 1'b0;
            err_r <= 1'b0;
            errh_r <= 16'h0000;
        end else begin
            op_enabled <= op_en_nxt;
            closed_loop <= special && m_cl;
            clkdir_mode <= m_clkdir;
            step_pulse <= m_clkdir && op_en_nxt && clk_s && !clk_d_r;
            step_dir <= dir_s;
            if (special) begin
                target_vel <= (op_en_nxt && !m_clkdir) ? spec_vel : 32'h0000_0000;
            end else begin
                target_vel <= tvel_host_r;
            end
            // set wins over software clear
            err_r <= chk_err || (err_r && !(wr_stat && wdata_r[SDM_STAT_ERR_BIT]));
            if (chk_err) errh_r <= chk_code;
            fault <= chk_err || (err_r && !(wr_stat && wdata_r[SDM_STAT_ERR_BIT]));
        end
    end

    // -----------------------------------------------------------------
    // read mux and responses
    // -----------------------------------------------------------------
    logic [31:0] rd_val;
    logic rd_hit;
    logic [31:0] stat_val;

    assign stat_val = {16'd0, 5'd0, fb_present, 3'd0, chk_busy, m_cl, special,
        op_enabled, err_r};
    assign rd_hit = (s_axi_araddr <= SDM_OFS_ACFG) && (s_axi_araddr[1:0] == 2'b00);

    always_comb begin
        rd_val = 32'h0000_0000;
        unique case (s_axi_araddr)
            SDM_OFS_CFG: rd_val = cfg_r;
            SDM_OFS_RES0: rd_val = res_r[0];
            SDM_OFS_RES1: rd_val = res_r[1];
            SDM_OFS_RES2: rd_val = res_r[2];
            SDM_OFS_CTRLW: rd_val = ctrlw_r;
            SDM_OFS_TVEL: rd_val = target_vel;
            SDM_OFS_STAT: rd_val = stat_val;
            SDM_OFS_ERRH: rd_val = {16'd0, errh_r};
            SDM_OFS_SCALE: rd_val = {21'd0, max_rpm};
            SDM_OFS_AOFS: rd_val = {19'd0, aofs};
            SDM_OFS_ACFG: rd_val = {20'd0, mode_r, act_r};
            default: rd_val = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= SDM_RESP_OKAY;
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= SDM_RESP_OKAY;
        end else begin
            if (wr_go) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_hit ? SDM_RESP_OKAY : SDM_RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            if (rd_go) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_hit ? rd_val : 32'h0000_0000;
                s_axi_rresp <= rd_hit ? SDM_RESP_OKAY : SDM_RESP_SLVERR;
                s_axi_arready <= 1'b0;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end
endmodule

// ### dv/sdm_ctrl_sva.sv
`timescale 1ns/1ns
module sdm_ctrl_sva (
    // clock, reset, pins
    input wire logic ref_clk, rst_n, din1_pin, dir_pin,
    // bus
    input wire logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready,
    input wire logic s_axi_bvalid, s_axi_bready,
    // motion
    input wire logic op_enabled, closed_loop, clkdir_mode, step_pulse, step_dir, fault,
    input wire logic [31:0] target_vel
);
    default clocking @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |-> ##2 s_axi_bvalid) else $error("late write answer");
    a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write answer dropped");
    a_enable_gate: assert property ((clkdir_mode && !din1_pin)[*4] |-> !op_enabled)
        else $error("enabled without enable input");
    a_clkdir_zero: assert property (clkdir_mode && $past(clkdir_mode) |-> target_vel == '0)
        else $error("speed in clock mode");
    a_step_mode: assert property (step_pulse |-> clkdir_mode && op_enabled)
        else $error("step outside clock mode");
    a_dir_follow: assert property (dir_pin == $past(dir_pin) && dir_pin == $past(dir_pin, 2)
        && dir_pin == $past(dir_pin, 3) |-> step_dir == dir_pin) else $error("direction lost");
    a_vel_bound: assert property (closed_loop && $past(closed_loop)
        |-> $signed(target_vel) <= 1000 && $signed(target_vel) >= -1000)
        else $error("speed above maximum");
    a_fault_clear: assert property ($fell(fault) |-> s_axi_bvalid || $past(s_axi_bvalid))
        else $error("error bit lost");
    c_step: cover property (step_pulse);
    c_fault: cover property ($rose(fault));
    c_reverse: cover property (closed_loop && target_vel[31]);
endmodule
bind sdm_ctrl sdm_ctrl_sva u_sdm_ctrl_sva (.ref_clk(ref_clk), .rst_n(rst_n),
    .din1_pin(din1_pin), .dir_pin(dir_pin), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .op_enabled(op_enabled),
    .closed_loop(closed_loop), .clkdir_mode(clkdir_mode), .step_pulse(step_pulse),
    .step_dir(step_dir), .fault(fault), .target_vel(target_vel));

// ### dv/sdm_motor_model.sv
`timescale 1ns/1ns
module sdm_motor_model
    import sdm_pkg::*;
(
    // clock and steps
    input wire logic ref_clk,
    input wire logic step_pulse,
    output int steps,
    // pins
    output logic din1_pin,
    output logic clk_pin,
    output logic dir_pin,
    output logic [SDM_NFB-1:0] fb_sig_pin,
    output logic [SDM_ADC_W-1:0] adc_code
);
    initial begin
        {din1_pin, clk_pin, dir_pin, fb_sig_pin, adc_code} = '0;
    end
    always @(posedge ref_clk) begin
        if (step_pulse)
            steps <= steps + 1;
    end
    // low feedback signal pin means no signal
    task automatic set(input logic en, input logic dr, input logic [SDM_NFB-1:0] fb,
        input logic [SDM_ADC_W-1:0] a);
        @(posedge ref_clk);
        din1_pin <= en;
        dir_pin <= dr;
        fb_sig_pin <= fb;
        adc_code <= a;
    endtask
    // step clock idles low outside a burst
    task automatic burst(input int n);
        repeat (n) begin
            @(posedge ref_clk);
            clk_pin <= 1'b1;
            repeat (4) @(posedge ref_clk);
            clk_pin <= 1'b0;
            repeat (3) @(posedge ref_clk);
        end
    endtask
endmodule

// ### dv/tb_special_drive_mode_control.sv
`timescale 1ns/1ns
module tb_special_drive_mode_control;
    import sdm_pkg::*;
    logic ref_clk, rst_n, awv, awr, wv, wrd, bv, br, arv, arr, rv, rr;
    logic din1, clkp, dirp, op_en, cl, cd, stp, sdir, flt;
    logic [7:0] aa, ra;
    logic [31:0] wdat, rdat, tv, rd_d, prev;
    logic [1:0] bres, rres, rd_r;
    logic [SDM_NFB-1:0] fbs;
    logic [SDM_ADC_W-1:0] adc;
    logic [3:0] mode;
    int steps, s0, mx, cyc = 0, error_cnt = 0, tests_run = 0;
    sdm_ctrl u_sdm_ctrl (.ref_clk(ref_clk), .rst_n(rst_n), .s_axi_awaddr(aa),
        .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wdat), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_bresp(bres), .s_axi_bvalid(bv),
        .s_axi_bready(br), .s_axi_araddr(ra), .s_axi_arvalid(arv), .s_axi_arready(arr),
        .s_axi_rdata(rdat), .s_axi_rresp(rres), .s_axi_rvalid(rv), .s_axi_rready(rr),
        .din1_pin(din1), .clk_pin(clkp), .dir_pin(dirp), .fb_sig_pin(fbs), .adc_code(adc),
        .op_enabled(op_en), .closed_loop(cl), .clkdir_mode(cd), .step_pulse(stp),
        .step_dir(sdir), .target_vel(tv), .fault(flt));
    sdm_motor_model u_sdm_motor_model (.ref_clk(ref_clk), .step_pulse(stp), .steps(steps),
        .din1_pin(din1), .clk_pin(clkp), .dir_pin(dirp), .fb_sig_pin(fbs), .adc_code(adc));
    // ---------------
    // tasks
    // ---------------
    task automatic print_verdict();
        $display("errors %0d in %0d checks", error_cnt, tests_run);
        if (error_cnt == 0 && tests_run > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        tests_run++;
        if (g !== e) begin
            error_cnt++;
            $display("mismatch at %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
        @(posedge ref_clk);
        aa <= a;
        wdat <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        br <= 1'b1;
        do begin
            @(posedge ref_clk);
            if (awr) awv <= 1'b0;
            if (wrd) wv <= 1'b0;
        end while (!bv);
        br <= 1'b0;
        chk(32'(bres), 32'(e));
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge ref_clk);
        ra <= a;
        arv <= 1'b1;
        rr <= 1'b1;
        do begin
            @(posedge ref_clk);
            if (arr) arv <= 1'b0;
        end while (!rv);
        rr <= 1'b0;
        rd_d = rdat;
        rd_r = rres;
    endtask
    task automatic apply(input logic [31:0] v);
        wr(SDM_OFS_CFG, v, SDM_RESP_OKAY);
        wr(SDM_OFS_CMD, 32'h0000_0001, SDM_RESP_OKAY);
        rd(SDM_OFS_ACFG);
        chk(32'(rd_d[11:0]), 32'(prev[11:0]));
        wr(SDM_OFS_CMD, 32'h0000_0002, SDM_RESP_OKAY);
        wt(12);
        rd(SDM_OFS_ACFG);
        chk(32'(rd_d[11:0]), 32'(v[11:0]));
        prev = v;
    endtask
    task automatic av(input logic en, input logic dr, input logic [11:0] a, input int e);
        u_sdm_motor_model.set(en, dr, 3'b111, a);
        wt(6);
        chk(tv, 32'(e));
    endtask
    // ---------------
    // sequence
    // ---------------
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            print_verdict();
        end
    end
    initial begin
        {rst_n, aa, ra, wdat, awv, wv, br, arv, rr, prev} = '0;
        wt(3);
        rst_n <= 1'b1;
        wt(12);
        chk(32'(flt), 32'h0);
        rd(8'h30);
        chk(32'(rd_r), 32'(SDM_RESP_SLVERR));
        wr(8'h31, 32'h0000_0001, SDM_RESP_SLVERR);
        wr(SDM_OFS_RES1, 32'h0000_0400, SDM_RESP_OKAY);
        wr(SDM_OFS_CMD, 32'h0000_0002, SDM_RESP_OKAY);
        wt(12);
        chk(32'(flt), 32'h1);
        rd(SDM_OFS_ERRH);
        chk(32'(rd_d[15:0]), 32'(SDM_ERR_BASE) + 32'h1);
        u_sdm_motor_model.set(1'b0, 1'b0, 3'b111, 12'h000);
        wr(SDM_OFS_STAT, 32'h0000_0001, SDM_RESP_OKAY);
        wt(2);
        chk(32'(flt), 32'h0);
        wr(SDM_OFS_CTRLW, 32'(SDM_CW_ENABLE), SDM_RESP_OKAY);
        wr(SDM_OFS_TVEL, 32'h0000_00c8, SDM_RESP_OKAY);
        wt(4);
        chk(tv, 32'h0000_00c8);
        chk(32'(op_en), 32'h1);
        wr(SDM_OFS_CTRLW, 32'(SDM_CW_SHUTDOWN), SDM_RESP_OKAY);
        wt(4);
        chk(32'(op_en), 32'h0);
        apply(32'h0000_0c01);
        chk(32'(cl), 32'h0);
        for (int m = 0; m < 16; m++) begin
            mode = 4'(m);
            mx = mode[0] ? 100 : 1000;
            apply({20'h0_0000, mode, 8'h02});
            chk(32'(cl), 32'(mode[3]));
            chk(32'(cd), 32'(mode[2:1] == 2'b00));
            if (mode[2]) begin
                rd(SDM_OFS_SCALE);
                chk(rd_d, 32'(mx));
                rd(SDM_OFS_AOFS);
                chk(rd_d, mode[1] ? 32'h0000_0800 : 32'h0000_0000);
            end
            u_sdm_motor_model.set(1'b1, 1'b0, 3'b111, 12'hfff);
            wt(6);
            chk(32'(op_en), 32'h1);
            wr(SDM_OFS_CTRLW, 32'(SDM_CW_SHUTDOWN), SDM_RESP_OKAY);
            wt(4);
            chk(32'(op_en), 32'h1);
            case (mode[2:1])
                2'b00: begin
                    av(1'b1, 1'b1, 12'h000, 0);
                    chk(32'(sdir), 32'h1);
                    s0 = steps;
                    u_sdm_motor_model.burst(3);
                    wt(4);
                    chk(32'(steps - s0), 32'h3);
                end
                2'b01: begin
                    av(1'b1, 1'b0, 12'hfff, mode[0] ? -30 : 30);
                    av(1'b0, 1'b0, 12'hfff, 0);
                    chk(32'(op_en), 32'h0);
                end
                2'b10: begin
                    av(1'b1, 1'b0, 12'hfff, mx);
                    av(1'b1, 1'b1, 12'hfff, -mx);
                    av(1'b1, 1'b0, 12'h008, 0);
                    av(1'b1, 1'b0, 12'h009, 9 * mx / 4095);
                    av(1'b1, 1'b0, 12'h800, 2048 * mx / 4095);
                end
                default: begin
                    av(1'b1, 1'b0, 12'hfff, mx);
                    av(1'b1, 1'b0, 12'h000, -mx);
                    av(1'b1, 1'b0, 12'h808, 0);
                    av(1'b1, 1'b0, 12'h7f8, 0);
                    av(1'b1, 1'b0, 12'h809, 9 * mx / 2047);
                end
            endcase
        end
        print_verdict();
    end
endmodule
